// ==== core/rtc_reg_file.sv ====
// Eight byte register file holding the BCD clock values and the control byte.
`timescale 1ns/100ps
`default_nettype none
module rtc_reg_file (
   input  wire logic   clk,            // System clock.
   input  wire logic   rstn,           // Asynchronous reset, active low.
   reg_port_if.store   port,           // Engine access.
   output logic [63:0] regs_flat       // All eight registers, index 0 lowest.
);
   logic [7:0] regs [0:rtc_port_pkg::reg_count-1];

   // Contents are stored as written; BCD form is the writer's duty and is passed through as-is.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < rtc_port_pkg::reg_count; i++) begin
            regs[i] <= (i == rtc_port_pkg::control_idx) ? rtc_port_pkg::control_init
                                                        : rtc_port_pkg::reg_init;
         end
      end else if (port.we) begin
         regs[port.index] <= port.wdata;
      end
   end

   assign port.rdata = regs[port.index];

   // One process drives the whole flat bus, so no byte of it has a second driver.
   always_comb begin
      for (int i = 0; i < rtc_port_pkg::reg_count; i++) begin
         regs_flat[i*8 +: 8] = regs[i];
      end
   end
endmodule
`default_nettype wire

// ==== core/rtc_two_wire_slave_port.sv ====
// Two-wire serial slave port reaching eight clock and control registers.
// How it works
// - Respond only after START and matching address
// - Eight registers, seconds through control, in order
// - Pointer advances after each written data byte and each master-acknowledged read byte
// - Registers hold BCD bytes as transferred
// - Data change during clock high is control
// - Data falling while clock high is START
// - Data rising while clock high is STOP
// - Sample data on clock rising edge
// - Unlimited bytes per transfer
// - Eight bits plus one acknowledge bit
// - Acknowledge address, pointer and data bytes
// - Hold data low through acknowledge clock high
// - Release data after missing master acknowledge
// - First write byte loads pointer
// - Read advances pointer on master acknowledge
// - Read without pointer write uses stored pointer
`timescale 1ns/100ps
`default_nettype none
module rtc_two_wire_slave_port (
   input  wire logic   clk,            // System clock, 20 MHz.
   input  wire logic   rstn,           // Asynchronous reset, active low.
   input  wire logic   scl_in,         // Serial clock pin level.
   input  wire logic   sda_in,         // Serial data pin level.
   output logic        sda_out,        // Serial data drive value, always low.
   output logic        sda_oe,         // Serial data drive enable, high pulls low.
   output logic [63:0] regs_flat       // Register contents for the timekeeping logic.
);
   // ------------------------------------------------------------
   // Pin synchronisers and condition detection
   // ------------------------------------------------------------
   logic scl_m, scl_s, scl_d;
   logic sda_m, sda_s, sda_d;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {scl_m, scl_s, scl_d} <= 3'h7;
         {sda_m, sda_s, sda_d} <= 3'h7;
      end else begin
         {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
         {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
      end
   end

   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_seen = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_seen  = scl_s & scl_d & ~sda_d & sda_s;

   // ------------------------------------------------------------
   // Byte engine
   // ------------------------------------------------------------
   reg_port_if rp ();

   rtc_reg_file store (
      .clk       (clk),
      .rstn      (rstn),
      .port      (rp.store),
      .regs_flat (regs_flat)
   );

   rtc_port_pkg::phase_type phase, after_ack;
   logic [2:0] bit_count;
   logic [7:0] shift;
   logic [2:0] pointer;
   logic       drive_low;
   logic       master_ack;
   logic       reload;

   wire byte_done  = scl_rise & (bit_count == 3'h7);
   wire [7:0] rx_byte = {shift[6:0], sda_s};
   wire addr_match = (rx_byte[7:1] == rtc_port_pkg::bus_address);

   assign rp.index = pointer;
   assign rp.wdata = rx_byte;
   assign rp.we    = byte_done & (phase == rtc_port_pkg::st_write);
   assign sda_out  = 1'b0;
   assign sda_oe   = drive_low;

   // The pointer wraps from control back to seconds so long transfers keep cycling.
   function automatic logic [2:0] next_index(input logic [2:0] p);
      return (p == rtc_port_pkg::last_index) ? 3'(rtc_port_pkg::seconds_idx) : p + 3'h1;
   endfunction

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phase      <= rtc_port_pkg::st_idle;
         after_ack  <= rtc_port_pkg::st_idle;
         bit_count  <= 3'h0;
         shift      <= 8'h00;
         pointer    <= rtc_port_pkg::pointer_init;
         drive_low  <= 1'b0;
         master_ack <= 1'b0;
      end else if (start_seen) begin
         phase     <= rtc_port_pkg::st_address;
         bit_count <= 3'h0;
         drive_low <= 1'b0;
      end else if (stop_seen) begin
         phase     <= rtc_port_pkg::st_idle;
         drive_low <= 1'b0;
      end else begin
         case (phase)
            rtc_port_pkg::st_address, rtc_port_pkg::st_pointer, rtc_port_pkg::st_write: begin
               if (scl_rise) begin
                  shift     <= rx_byte;
                  bit_count <= bit_count + 3'h1;
               end
               if (byte_done) begin
                  if (phase == rtc_port_pkg::st_address) begin
                     if (!addr_match) begin
                        phase <= rtc_port_pkg::st_ignore;
                     end else begin
                        phase     <= rtc_port_pkg::st_ack;
                        after_ack <= rx_byte[0] ? rtc_port_pkg::st_read
                                                : rtc_port_pkg::st_pointer;
                     end
                  end else if (phase == rtc_port_pkg::st_pointer) begin
                     pointer   <= rx_byte[2:0];
                     phase     <= rtc_port_pkg::st_ack;
                     after_ack <= rtc_port_pkg::st_write;
                  end else begin
                     pointer   <= next_index(pointer);
                     phase     <= rtc_port_pkg::st_ack;
                     after_ack <= rtc_port_pkg::st_write;
                  end
               end
            end
            rtc_port_pkg::st_ack: begin
               // Drive low from the falling edge after the eighth bit to the next falling edge.
               if (scl_fall) begin
                  drive_low <= ~drive_low;
                  if (drive_low) begin
                     phase     <= after_ack;
                     bit_count <= 3'h0;
                     shift     <= rp.rdata;
                     if (after_ack == rtc_port_pkg::st_read) begin
                        drive_low <= ~rp.rdata[7];
                     end
                  end
               end
            end
            rtc_port_pkg::st_read: begin
               // One cycle after an acknowledged byte the stepped pointer reaches the port.
               if (reload) begin
                  shift     <= rp.rdata;
                  drive_low <= ~rp.rdata[7];
               end else if (scl_fall) begin
                  bit_count <= bit_count + 3'h1;
                  if (bit_count == 3'h7) begin
                     drive_low <= 1'b0;
                     phase     <= rtc_port_pkg::st_ackrd;
                  end else begin
                     drive_low <= ~shift[6];
                     shift     <= {shift[6:0], 1'b0};
                  end
               end
            end
            rtc_port_pkg::st_ackrd: begin
               if (scl_rise) begin
                  master_ack <= ~sda_s;
               end
               if (scl_fall) begin
                  if (master_ack) begin
                     pointer <= next_index(pointer);
                     phase   <= rtc_port_pkg::st_read;
                     bit_count <= 3'h0;
                  end else begin
                     phase <= rtc_port_pkg::st_ignore;
                  end
               end
            end
            rtc_port_pkg::st_idle, rtc_port_pkg::st_ignore: begin
               drive_low <= 1'b0;
            end
            default: begin
               phase <= rtc_port_pkg::st_idle;
            end
         endcase
      end
   end

   // The register port shows the stepped pointer only one cycle after the falling edge,
   // so the next read byte is loaded then; the clock low phase leaves ample room for it.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reload <= 1'b0;
      end else begin
         reload <= (phase == rtc_port_pkg::st_ackrd) & scl_fall & master_ack;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_start_rearms;
      @(posedge clk) disable iff (!rstn) start_seen |=> phase == rtc_port_pkg::st_address;
   endproperty
   a_start_rearms: assert property (p_start_rearms) else $error("start did not rearm");

   property p_stop_idle;
      @(posedge clk) disable iff (!rstn) stop_seen & ~start_seen |=> !sda_oe;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("drive after stop");

   property p_mismatch_quiet;
      @(posedge clk) disable iff (!rstn) phase == rtc_port_pkg::st_ignore |-> !sda_oe;
   endproperty
   a_mismatch_quiet: assert property (p_mismatch_quiet) else $error("drive while ignoring");

   property p_write_steps;
      @(posedge clk) disable iff (!rstn) rp.we & ~start_seen & ~stop_seen
         |=> pointer == next_index($past(pointer));
   endproperty
   a_write_steps: assert property (p_write_steps) else $error("pointer not advanced");

   property p_ack_held;
      @(posedge clk) disable iff (!rstn)
         phase == rtc_port_pkg::st_ack & sda_oe & scl_s & ~start_seen & ~stop_seen |=> sda_oe;
   endproperty
   a_ack_held: assert property (p_ack_held) else $error("ack released in high");

   property p_nack_release;
      @(posedge clk) disable iff (!rstn)
         phase == rtc_port_pkg::st_ackrd & ~master_ack & scl_fall & ~start_seen & ~stop_seen
         |=> phase == rtc_port_pkg::st_ignore ##1 !sda_oe;
   endproperty
   a_nack_release: assert property (p_nack_release) else $error("no release on nack");

   property p_read_ack_steps;
      @(posedge clk) disable iff (!rstn)
         phase == rtc_port_pkg::st_ackrd & master_ack & scl_fall & ~start_seen & ~stop_seen
         |=> pointer == next_index($past(pointer));
   endproperty
   a_read_ack_steps: assert property (p_read_ack_steps) else $error("read pointer stuck");

   property p_pointer_load;
      @(posedge clk) disable iff (!rstn)
         byte_done & phase == rtc_port_pkg::st_pointer & ~start_seen & ~stop_seen
         |=> pointer == shift[2:0];
   endproperty
   a_pointer_load: assert property (p_pointer_load) else $error("pointer not loaded");
endmodule
`default_nettype wire

// ==== pkg/reg_port_if.sv ====
// Register write and read path between the serial engine and the register file.
`timescale 1ns/100ps
`default_nettype none
interface reg_port_if;
   logic [2:0] index;
   logic [7:0] wdata;
   logic       we;
   logic [7:0] rdata;
   modport engine (output index, output wdata, output we, input rdata);
   modport store  (input index, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// ==== pkg/rtc_port_pkg.sv ====
// Constants shared by the two-wire clock register port.
package rtc_port_pkg;
   localparam logic [6:0] bus_address  = 7'h68;   // Address byte 8'hD0 with direction bit zero.
   localparam int         reg_count    = 8;
   localparam logic [2:0] last_index   = 3'h7;
   localparam logic [2:0] pointer_init = 3'h0;
   localparam logic [7:0] reg_init     = 8'h00;
   localparam logic [7:0] control_init = 8'h80;   // Output bit set at power-on.
   localparam int         seconds_idx  = 0;
   localparam int         control_idx  = 7;
   typedef enum logic [2:0] {
      st_idle    = 3'b000,
      st_address = 3'b001,
      st_pointer = 3'b010,
      st_write   = 3'b011,
      st_read    = 3'b100,
      st_ack     = 3'b101,
      st_ackrd   = 3'b110,
      st_ignore  = 3'b111
   } phase_type;
endpackage

// ==== tb/rtc_two_wire_slave_port_tb_top.sv ====
// Self-checking testbench for the two-wire clock register port.
`timescale 1ns/100ps
`default_nettype none
module rtc_two_wire_slave_port_tb_top;
   logic        clk;
   logic        rstn;
   logic        scl;
   logic        sda_drv;
   logic        sda_out;
   logic        sda_oe;
   logic [63:0] regs_flat;
   logic        a;
   logic [7:0]  d;
   int          miscompares = 0;
   int          num_checks = 0;
   // The wire has a pull-up, so it is low only while some party pulls it.
   wire logic   sda_line = sda_drv & ~(sda_oe & ~sda_out);
   localparam logic [7:0] wdat [3] = '{8'h59, 8'h23, 8'h45};

   rtc_two_wire_slave_port u_dut (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .regs_flat(regs_flat));
   two_wire_master_model u_mst (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

   task automatic check_bit(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic reset_values;
      check_bit("sda_oe", 1'b0, sda_oe);
      check_bit("sda_out", 1'b0, sda_out);
      for (int i = 0; i < 7; i++) check_byte("reg reset", rtc_port_pkg::reg_init, regs_flat[8*i +: 8]);
      check_byte("control reset", rtc_port_pkg::control_init, regs_flat[63:56]);
   endtask
   // Starts at index 6 so that the burst wraps from the control byte to seconds.
   task automatic write_burst;
      u_mst.start_cond();
      u_mst.wr_byte(8'hD0, a);
      check_bit("address ack", 1'b1, a);
      u_mst.wr_byte(8'h06, a);
      check_bit("pointer ack", 1'b1, a);
      foreach (wdat[i]) begin
         u_mst.wr_byte(wdat[i], a);
         check_bit("data ack", 1'b1, a);
      end
      u_mst.stop_cond();
      check_byte("reg6", 8'h59, regs_flat[55:48]);
      check_byte("reg7", 8'h23, regs_flat[63:56]);
      check_byte("reg0 after wrap", 8'h45, regs_flat[7:0]);
   endtask
   task automatic read_back;
      u_mst.start_cond();
      u_mst.wr_byte(8'hD0, a);
      u_mst.wr_byte(8'h06, a);
      u_mst.start_cond();
      u_mst.wr_byte(8'hD1, a);
      check_bit("read address ack", 1'b1, a);
      for (int i = 0; i < 3; i++) begin
         u_mst.rd_byte(i < 2, d);
         check_byte("read data", wdat[i], d);
      end
      // Let the clock fall after the missing acknowledge, where a next byte would start.
      u_mst.step(1'b0, 1'b1);
      check_bit("released on nack", 1'b0, sda_oe);
      u_mst.stop_cond();
      u_mst.start_cond();
      u_mst.wr_byte(8'hD1, a);
      u_mst.rd_byte(1'b0, d);
      check_byte("stored pointer read", 8'h45, d);
      u_mst.stop_cond();
   endtask
   task automatic foreign_address;
      u_mst.start_cond();
      u_mst.wr_byte(8'hA0, a);
      check_bit("foreign address ack", 1'b0, a);
      u_mst.wr_byte(8'h02, a);
      check_bit("ignored byte ack", 1'b0, a);
      u_mst.wr_byte(8'h99, a);
      u_mst.stop_cond();
      check_byte("reg2 untouched", 8'h00, regs_flat[23:16]);
   endtask
   // A stop in mid-byte must leave the register alone and rearm address matching.
   task automatic abort_mid_byte;
      u_mst.start_cond();
      u_mst.wr_byte(8'hD0, a);
      u_mst.wr_byte(8'h01, a);
      for (int i = 0; i < 4; i++) u_mst.xfer_bit(1'b1, a);
      u_mst.stop_cond();
      check_byte("reg1 after abort", 8'h00, regs_flat[15:8]);
      u_mst.start_cond();
      u_mst.wr_byte(8'hD0, a);
      check_bit("address ack after abort", 1'b1, a);
      u_mst.wr_byte(8'h01, a);
      u_mst.wr_byte(8'h37, a);
      u_mst.stop_cond();
      check_byte("reg1 bcd", 8'h37, regs_flat[15:8]);
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #1000000;
      miscompares++;
      tally_and_finish();
   end
   initial begin
      rstn = 1'b0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      reset_values();
      write_burst();
      read_back();
      foreign_address();
      abort_mid_byte();
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ==== tb/two_wire_master_model.sv ====
// Behavioural two-wire bus master that drives the serial clock and data lines.
`timescale 1ns/100ps
`default_nettype none
module two_wire_master_model (
   input  wire logic clk,        // System clock.
   input  wire logic sda_line,   // Resolved level of the data wire.
   output logic      scl,        // Serial clock drive.
   output logic      sda_drv     // Data drive, one releases to the pull-up.
);
   // Each phase lasts six clocks, which leaves room for the port's synchronisers.
   localparam int half = 6;
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic step(input logic c, input logic d);
      @(posedge clk);
      scl <= c;
      sda_drv <= d;
      repeat (half - 1) @(posedge clk);
   endtask
   task automatic start_cond;
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask
   task automatic stop_cond;
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   task automatic xfer_bit(input logic b, output logic s);
      step(1'b0, b);
      step(1'b1, b);
      #1 s = sda_line;
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) xfer_bit(d[i], s);
      xfer_bit(1'b1, s);
      ack = ~s;
   endtask
   task automatic rd_byte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) xfer_bit(1'b1, d[i]);
      xfer_bit(~ack, s);
   endtask
endmodule
`default_nettype wire
